// ---- verilog/tlp_chk_pkg.sv ----
package tlp_chk_pkg;

    // ==========================================
    // Check result vector layout
    // ==========================================
    localparam int CAUSE_W = 11;
    localparam int C_TAG = 0;
    localparam int C_CROSS4K = 1;
    localparam int C_IO = 2;
    localparam int C_CFG = 3;
    localparam int C_FUNC = 4;
    localparam int C_INTX_DIR = 5;
    localparam int C_INTX_TC = 6;
    localparam int C_PM_TC = 7;
    localparam int C_ERR_TC = 8;
    localparam int C_UNLOCK_TC = 9;
    localparam int C_SSPL_TC = 10;

    // ==========================================
    // Header field widths
    // ==========================================
    localparam int TAG_W = 8;
    localparam int TAG_NARROW_W = 5;
    localparam int FUNC_W = 3;
    localparam int NUM_FUNC = 8;
    localparam int ADDR_DW_W = 10;
    localparam int LEN_W = 10;

    // ==========================================
    // Fmt and Type encodings
    // ==========================================
    localparam int FMT_DATA_BIT = 1;
    localparam int FMT_PREFIX_BIT = 2;
    localparam logic [4:0] TYPE_MEM = 5'h00;
    localparam logic [4:0] TYPE_MEM_LK = 5'h01;
    localparam logic [4:0] TYPE_IO = 5'h02;
    localparam logic [4:0] TYPE_CFG0 = 5'h04;
    localparam logic [4:0] TYPE_CFG1 = 5'h05;
    localparam logic [1:0] TYPE_MSG_TOP = 2'h2;

    // ==========================================
    // Required field values
    // ==========================================
    localparam logic [2:0] TC_ZERO = 3'h0;
    localparam logic [1:0] ATTR_ZERO = 2'h0;
    localparam logic [1:0] AT_ZERO = 2'h0;
    localparam logic [9:0] LEN_ONE_DW = 10'h001;
    localparam logic [3:0] LAST_BE_ZERO = 4'h0;
    localparam logic [10:0] DW_PER_4K = 11'h400;

    // ==========================================
    // Message codes
    // ==========================================
    localparam logic [7:0] MSG_UNLOCK = 8'h00;
    localparam logic [4:0] MSG_INTX_TOP = 5'h04;
    localparam logic [7:0] MSG_PM_NAK = 8'h14;
    localparam logic [7:0] MSG_PM_PME = 8'h18;
    localparam logic [7:0] MSG_PME_OFF = 8'h19;
    localparam logic [7:0] MSG_PME_ACK = 8'h1b;
    localparam logic [7:0] MSG_ERR_COR = 8'h30;
    localparam logic [7:0] MSG_ERR_NF = 8'h31;
    localparam logic [7:0] MSG_ERR_FAT = 8'h33;
    localparam logic [7:0] MSG_SSPL = 8'h50;

    // ==========================================
    // Reset values
    // ==========================================
    localparam logic RST_VALID = 1'b0;
    localparam logic RST_MALFORMED = 1'b0;
    localparam logic [CAUSE_W-1:0] RST_CAUSE = 11'h000;

endpackage

// ---- verilog/tlp_rx_checker.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Only received TLPs are checked; transmit checks belong to user logic.
// RULE2: Received request tag must fit the configured tag width.
// RULE3: User logic checks tags of memory and I/O requests both ways; the model checks received ones only.
// RULE4: Received memory write crossing a 4 KB boundary is malformed.
// RULE5: User logic may flag memory reads crossing 4 KB; not checked here.
// RULE6: I/O request needs TC, Attr, AT zero, length one, last BE zero.
// RULE7: Config request needs TC, Attr, AT zero, length one, last BE zero.
// RULE8: Config request must target a valid function number.
// RULE9: INTx message not sent by an upstream port is malformed.
// RULE10: INTx message on a traffic class other than TC0 is malformed.
// RULE11: Power management message not on TC0 is malformed.
// RULE12: Error signaling message not on TC0 is malformed.
// RULE13: Unlock message not on TC0 is malformed.
// RULE14: Slot power limit message not on TC0 is malformed.
// RULE15: User logic reports unsupported vendor type 0, ignores type 1; the model passes vendor type 0 without a report as well.
// RULE16: User logic reports unsupported message codes.
// RULE17: User logic may flag LTR messages not on TC0.
// RULE18: User logic may flag prefixes lacking a following header.
// RULE19: User logic may flag local prefixes after end-to-end ones.
// RULE20: User logic may flag unsupported local prefix types.
// RULE21: User logic may flag more than four end-to-end prefixes.
// RULE22: User logic may flag unsupported end-to-end prefixes.
// RULE23: User logic may flag reserved Fmt and Type encodings.
// RULE24: User logic discards failed TLPs and signals the error same cycle.
module tlp_rx_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Received header, valid for one cycle
    input wire logic hdr_valid,
    input wire logic [2:0] hdr_fmt,
    input wire logic [4:0] hdr_type,
    input wire logic [2:0] hdr_tc,
    input wire logic [1:0] hdr_attr,
    input wire logic [1:0] hdr_at,
    input wire logic [tlp_chk_pkg::LEN_W-1:0] hdr_length,
    input wire logic [3:0] hdr_last_be,
    input wire logic [tlp_chk_pkg::TAG_W-1:0] hdr_tag,
    input wire logic [tlp_chk_pkg::ADDR_DW_W-1:0] hdr_addr_dw,
    input wire logic [tlp_chk_pkg::FUNC_W-1:0] hdr_func,
    input wire logic [7:0] hdr_msg_code,
    // Configuration state
    input wire logic ext_tag_en,
    input wire logic [tlp_chk_pkg::NUM_FUNC-1:0] func_enabled,
    input wire logic port_downstream,
    // Check result, one cycle after the header
    output logic chk_valid,
    output logic chk_malformed,
    output logic [tlp_chk_pkg::CAUSE_W-1:0] chk_cause
);
    import tlp_chk_pkg::*;

    // ==========================================
    // Header classification
    // ==========================================
    logic is_msg;
    logic is_mem;
    logic is_mem_wr;
    logic is_io;
    logic is_cfg;
    logic is_req;
    logic is_intx;
    logic is_pm;
    logic is_err;
    logic is_unlock;
    logic is_sspl;
    logic tc_nonzero;
    logic [10:0] len_dw;
    logic [10:0] end_dw;

    always_comb begin
        is_msg = (hdr_type[4:3] == TYPE_MSG_TOP);
        is_mem = (hdr_type == TYPE_MEM) || (hdr_type == TYPE_MEM_LK);
        is_mem_wr = (hdr_type == TYPE_MEM) && hdr_fmt[FMT_DATA_BIT];
        is_io = (hdr_type == TYPE_IO);
        is_cfg = (hdr_type == TYPE_CFG0) || (hdr_type == TYPE_CFG1);
        is_req = is_mem || is_io || is_cfg;
        is_intx = is_msg && (hdr_msg_code[7:3] == MSG_INTX_TOP);
        is_pm = is_msg && ((hdr_msg_code == MSG_PM_NAK)
            || (hdr_msg_code == MSG_PM_PME)
            || (hdr_msg_code == MSG_PME_OFF)
            || (hdr_msg_code == MSG_PME_ACK));
        is_err = is_msg && ((hdr_msg_code == MSG_ERR_COR)
            || (hdr_msg_code == MSG_ERR_NF)
            || (hdr_msg_code == MSG_ERR_FAT));
        is_unlock = is_msg && (hdr_msg_code == MSG_UNLOCK);
        is_sspl = is_msg && (hdr_msg_code == MSG_SSPL);
        tc_nonzero = (hdr_tc != TC_ZERO);
        // A length field of zero means a full 1024 doublewords
        len_dw = (hdr_length == '0) ? DW_PER_4K : {1'b0, hdr_length};
        end_dw = {1'b0, hdr_addr_dw} + len_dw;
    end

    // ==========================================
    // Individual checks
    // ==========================================
    logic [CAUSE_W-1:0] cause;
    logic narrow_fields_bad;

    always_comb begin
        // Shared restrictions of I/O and config requests
        narrow_fields_bad = tc_nonzero
            || (hdr_attr != ATTR_ZERO)
            || (hdr_at != AT_ZERO)
            || (hdr_length != LEN_ONE_DW)
            || (hdr_last_be != LAST_BE_ZERO);
        cause = '0;
        // Upper tag bits are only legal with extended tags
        cause[C_TAG] = is_req && !ext_tag_en
            && (hdr_tag[TAG_W-1:TAG_NARROW_W] != '0); // RULE2
        cause[C_CROSS4K] = is_mem_wr && (end_dw > DW_PER_4K); // RULE4
        cause[C_IO] = is_io && narrow_fields_bad; // RULE6
        cause[C_CFG] = is_cfg && narrow_fields_bad; // RULE7
        cause[C_FUNC] = is_cfg && !func_enabled[hdr_func]; // RULE8
        // INTx only travels upstream, so only a downstream port sinks it
        cause[C_INTX_DIR] = is_intx && !port_downstream; // RULE9
        cause[C_INTX_TC] = is_intx && tc_nonzero; // RULE10
        cause[C_PM_TC] = is_pm && tc_nonzero; // RULE11
        cause[C_ERR_TC] = is_err && tc_nonzero; // RULE12
        cause[C_UNLOCK_TC] = is_unlock && tc_nonzero; // RULE13
        cause[C_SSPL_TC] = is_sspl && tc_nonzero; // RULE14
    end

    // ==========================================
    // Result registers
    // ==========================================
    logic valid_q;
    logic valid_d;
    logic malformed_q;
    logic malformed_d;
    logic [CAUSE_W-1:0] cause_q;
    logic [CAUSE_W-1:0] cause_d;

    always_comb begin
        // Only the receive header path feeds the checks
        valid_d = hdr_valid; // RULE1
        cause_d = hdr_valid ? cause : '0;
        malformed_d = hdr_valid && (cause != '0);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            valid_q <= RST_VALID;
            malformed_q <= RST_MALFORMED;
            cause_q <= RST_CAUSE;
        end else begin
            valid_q <= valid_d;
            malformed_q <= malformed_d;
            cause_q <= cause_d;
        end
    end

    assign chk_valid = valid_q;
    assign chk_malformed = malformed_q;
    assign chk_cause = cause_q;

    // ==========================================
    // Checks on the result
    // ==========================================
    property p_tag;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && (hdr_type == TYPE_IO) && !ext_tag_en
            && hdr_tag[TAG_W-1]
        |=> chk_malformed && chk_cause[C_TAG];
    endproperty
    a_tag: assert property (p_tag) // RULE2
        else $error("Wide tag not flagged");

    property p_cross4k;
        @(posedge core_clk) disable iff (!arst_n)
        chk_cause[C_CROSS4K] |-> $past(hdr_valid)
            && $past(hdr_fmt[FMT_DATA_BIT])
            && ($past(hdr_type) == TYPE_MEM);
    endproperty
    a_cross4k: assert property (p_cross4k) // RULE4
        else $error("Boundary flag without memory write");

    property p_cross4k_last;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_mem_wr && (hdr_addr_dw == 10'h3ff)
            && (hdr_length == LEN_ONE_DW)
        ##1 1'b1 |-> !chk_cause[C_CROSS4K];
    endproperty
    a_cross4k_last: assert property (p_cross4k_last) // RULE4
        else $error("Last doubleword write wrongly flagged");

    property p_io;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_io && (hdr_length != LEN_ONE_DW)
        |=> chk_valid && chk_malformed && chk_cause[C_IO];
    endproperty
    a_io: assert property (p_io) // RULE6
        else $error("Bad I/O length not flagged");

    property p_cfg;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_cfg && (hdr_attr == ATTR_ZERO)
            && (hdr_at == AT_ZERO) && !tc_nonzero
            && (hdr_length == LEN_ONE_DW)
            && (hdr_last_be == LAST_BE_ZERO)
        |=> !chk_cause[C_CFG];
    endproperty
    a_cfg: assert property (p_cfg) // RULE7
        else $error("Clean config request flagged");

    property p_func;
        @(posedge core_clk) disable iff (!arst_n)
        chk_cause[C_FUNC] |-> !$past(func_enabled[hdr_func])
            && chk_malformed;
    endproperty
    a_func: assert property (p_func) // RULE8
        else $error("Function flag without bad function");

    property p_intx_dir;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_intx && !port_downstream
        ##1 chk_valid |-> chk_cause[C_INTX_DIR];
    endproperty
    a_intx_dir: assert property (p_intx_dir) // RULE9
        else $error("INTx at upstream port not flagged");

    property p_intx_tc;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_intx |=> chk_cause[C_INTX_TC]
            == ($past(hdr_tc) != TC_ZERO);
    endproperty
    a_intx_tc: assert property (p_intx_tc) // RULE10
        else $error("INTx class check wrong");

    property p_pm_tc;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_msg && (hdr_msg_code == MSG_PME_OFF)
            && tc_nonzero |=> chk_cause[C_PM_TC];
    endproperty
    a_pm_tc: assert property (p_pm_tc) // RULE11
        else $error("PM message class not flagged");

    property p_err_tc;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_msg && (hdr_msg_code == MSG_ERR_FAT)
            && tc_nonzero |=> chk_malformed;
    endproperty
    a_err_tc: assert property (p_err_tc) // RULE12
        else $error("Error message class not flagged");

    property p_unlock_tc;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_unlock && tc_nonzero
        |=> chk_cause[C_UNLOCK_TC] ##1 !chk_cause[C_UNLOCK_TC]
            || $past(hdr_valid);
    endproperty
    a_unlock_tc: assert property (p_unlock_tc) // RULE13
        else $error("Unlock class flag wrong");

    property p_sspl_tc;
        @(posedge core_clk) disable iff (!arst_n)
        chk_cause[C_SSPL_TC] |-> ($past(hdr_msg_code) == MSG_SSPL)
            && ($past(hdr_tc) != TC_ZERO);
    endproperty
    a_sspl_tc: assert property (p_sspl_tc) // RULE14
        else $error("Power limit flag without cause");

    property p_idle;
        @(posedge core_clk) disable iff (!arst_n)
        !hdr_valid |=> !chk_valid && !chk_malformed
            && (chk_cause == '0);
    endproperty
    a_idle: assert property (p_idle) // RULE1
        else $error("Result without received header");

    property p_valid;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid |=> chk_valid;
    endproperty
    a_valid: assert property (p_valid) // RULE1
        else $error("Received header gave no result");

    property p_malformed;
        @(posedge core_clk) disable iff (!arst_n)
        chk_valid |-> chk_malformed == (chk_cause != '0);
    endproperty
    a_malformed: assert property (p_malformed) // RULE1
        else $error("Malformed flag disagrees with causes");

    property p_cross4k_hit;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_mem_wr && (hdr_addr_dw == 10'h3ff)
            && (hdr_length == 10'h002)
        |=> chk_cause[C_CROSS4K];
    endproperty
    a_cross4k_hit: assert property (p_cross4k_hit) // RULE4
        else $error("Boundary crossing write not flagged");

    property p_func_ok;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_cfg && func_enabled[hdr_func]
        |=> !chk_cause[C_FUNC];
    endproperty
    a_func_ok: assert property (p_func_ok) // RULE8
        else $error("Existing function flagged");

    property p_sspl_hit;
        @(posedge core_clk) disable iff (!arst_n)
        hdr_valid && is_sspl && tc_nonzero |=> chk_cause[C_SSPL_TC];
    endproperty
    a_sspl_hit: assert property (p_sspl_hit) // RULE14
        else $error("Power limit class not flagged");

endmodule

// ---- bench/user_app_model.sv ----
`timescale 1ns/1ps
module user_app_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Header seen on the receive path
    input wire logic hdr_valid,
    input wire logic [2:0] hdr_fmt,
    input wire logic [4:0] hdr_type,
    input wire logic [2:0] hdr_tc,
    input wire logic [7:0] hdr_tag,
    input wire logic [9:0] hdr_addr_dw,
    input wire logic [9:0] hdr_length,
    input wire logic [7:0] hdr_msg_code,
    input wire logic ext_tag_en,
    // Result from the block
    input wire logic chk_valid,
    input wire logic chk_malformed,
    // User side error reports
    output logic drop_tlp,
    output logic report_ur
);
    import tlp_chk_pkg::*;
    logic ur_d;
    logic ur_q;
    logic bad_d;
    logic bad_q;
    logic [10:0] span;

    // ==========================================
    // User side malformed checks
    // ==========================================
    always_comb begin
        span = {1'b0, hdr_addr_dw}
            + ((hdr_length == '0) ? DW_PER_4K : {1'b0, hdr_length});
        bad_d = 1'b0;
        if (hdr_valid) begin
            if ((hdr_type inside {TYPE_MEM, TYPE_MEM_LK, TYPE_IO})
                && !ext_tag_en && (hdr_tag[7:5] != 3'h0))
                bad_d = 1'b1;
            if ((hdr_type == TYPE_MEM) && !hdr_fmt[FMT_DATA_BIT]
                && (span > DW_PER_4K))
                bad_d = 1'b1;
            if ((hdr_type[4:3] == TYPE_MSG_TOP) && (hdr_msg_code == 8'h10)
                && (hdr_tc != TC_ZERO))
                bad_d = 1'b1;
            // No prefixes supported, so every prefix is refused
            if (hdr_fmt[FMT_PREFIX_BIT])
                bad_d = 1'b1;
            if (!(hdr_type inside {TYPE_MEM, TYPE_MEM_LK, TYPE_IO, TYPE_CFG0,
                TYPE_CFG1, 5'h0a, 5'h0b}) && (hdr_type[4:3] != TYPE_MSG_TOP))
                bad_d = 1'b1;
        end
    end

    // ==========================================
    // Message support decision
    // ==========================================
    // Only vendor type 0, vendor type 1 and the ignored codes pass
    always_comb begin
        ur_d = 1'b0;
        if (hdr_valid && hdr_type[4:3] == TYPE_MSG_TOP) begin
            ur_d = !(hdr_msg_code inside {8'h7e, 8'h7f, 8'h40, 8'h41,
                8'h43, 8'h44, 8'h45, 8'h47, 8'h48});
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ur_q <= 1'b0;
            bad_q <= 1'b0;
        end else begin
            ur_q <= ur_d;
            bad_q <= bad_d;
        end
    end

    // Lined up with the block's verdict so both land in one cycle
    assign drop_tlp = chk_valid && (chk_malformed || ur_q || bad_q);
    assign report_ur = chk_valid && ur_q;
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    import tlp_chk_pkg::*;
    // ==========================================
    // Signals
    // ==========================================
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic hdr_valid = 1'b0;
    logic [2:0] hdr_fmt = 3'h0, hdr_tc = 3'h0;
    logic [4:0] hdr_type = 5'h00;
    logic [1:0] hdr_attr = 2'h0, hdr_at = 2'h0;
    logic [9:0] hdr_length = 10'h001, hdr_addr_dw = 10'h000;
    logic [3:0] hdr_last_be = 4'h0;
    logic [7:0] hdr_tag = 8'h00, hdr_msg_code = 8'h00;
    logic [2:0] hdr_func = 3'h0;
    logic ext_tag_en = 1'b1, port_downstream = 1'b1;
    logic [NUM_FUNC-1:0] func_enabled = 8'hff;
    logic chk_valid, chk_malformed, drop_tlp, report_ur;
    logic [CAUSE_W-1:0] chk_cause, pend_c = 11'h000;
    logic pend_v = 1'b0;
    logic [1:0] pend_u = 2'h0;
    logic [31:0] rng_q = 32'h0000_0061, r1, r2;
    logic [7:0] codes [12] = '{8'h00, 8'h20, 8'h27, 8'h14, 8'h18, 8'h19,
        8'h1b, 8'h30, 8'h31, 8'h33, 8'h50, 8'h7e};
    int err_count = 0;
    int n_tests = 0;

    always #5 core_clk = ~core_clk;

    tlp_rx_checker tlp_rx_checker_i (.core_clk(core_clk), .arst_n(arst_n),
        .hdr_valid(hdr_valid), .hdr_fmt(hdr_fmt), .hdr_type(hdr_type),
        .hdr_tc(hdr_tc), .hdr_attr(hdr_attr), .hdr_at(hdr_at),
        .hdr_length(hdr_length), .hdr_last_be(hdr_last_be),
        .hdr_tag(hdr_tag), .hdr_addr_dw(hdr_addr_dw), .hdr_func(hdr_func),
        .hdr_msg_code(hdr_msg_code), .ext_tag_en(ext_tag_en),
        .func_enabled(func_enabled), .port_downstream(port_downstream),
        .chk_valid(chk_valid), .chk_malformed(chk_malformed),
        .chk_cause(chk_cause));
    user_app_model user_app_model_i (.core_clk(core_clk), .arst_n(arst_n),
        .hdr_valid(hdr_valid), .hdr_fmt(hdr_fmt), .hdr_type(hdr_type),
        .hdr_tc(hdr_tc), .hdr_tag(hdr_tag), .hdr_addr_dw(hdr_addr_dw),
        .hdr_length(hdr_length), .hdr_msg_code(hdr_msg_code),
        .ext_tag_en(ext_tag_en), .chk_valid(chk_valid),
        .chk_malformed(chk_malformed), .drop_tlp(drop_tlp),
        .report_ur(report_ur));

    // ==========================================
    // Helpers
    // ==========================================
    function automatic logic [31:0] rnd();
        rng_q ^= rng_q << 13;
        rng_q ^= rng_q >> 17;
        rng_q ^= rng_q << 5;
        return rng_q;
    endfunction

    // Upper bit: unsupported request, lower bit: user side malformed
    function automatic logic [1:0] exp_user();
        logic msg, bad;
        logic [10:0] span;
        msg = hdr_type[4:3] == TYPE_MSG_TOP;
        span = {1'b0, hdr_addr_dw} +
            ((hdr_length == 10'h000) ? DW_PER_4K : {1'b0, hdr_length});
        bad = hdr_fmt[2] || (!ext_tag_en && hdr_tag[7:5] != 3'h0 &&
            hdr_type inside {TYPE_MEM, TYPE_MEM_LK, TYPE_IO});
        bad |= hdr_type == TYPE_MEM && !hdr_fmt[1] && span > DW_PER_4K;
        bad |= msg && hdr_msg_code == 8'h10 && hdr_tc != TC_ZERO;
        bad |= !msg && !(hdr_type inside {TYPE_MEM, TYPE_MEM_LK, TYPE_IO,
            TYPE_CFG0, TYPE_CFG1, 5'h0a, 5'h0b});
        return {msg && !(hdr_msg_code inside {8'h7e, 8'h7f, 8'h40, 8'h41,
            8'h43, 8'h44, 8'h45, 8'h47, 8'h48}), bad};
    endfunction

    function automatic logic [CAUSE_W-1:0] exp_cause();
        logic [CAUSE_W-1:0] c;
        logic req, msg, cfg, bad, tcb, intx;
        logic [10:0] span;
        req = hdr_type inside {TYPE_MEM, TYPE_MEM_LK, TYPE_IO, TYPE_CFG0,
            TYPE_CFG1};
        msg = hdr_type[4:3] == TYPE_MSG_TOP;
        cfg = hdr_type inside {TYPE_CFG0, TYPE_CFG1};
        tcb = hdr_tc != TC_ZERO;
        bad = tcb || hdr_attr != ATTR_ZERO || hdr_at != AT_ZERO ||
            hdr_length != LEN_ONE_DW || hdr_last_be != LAST_BE_ZERO;
        span = {1'b0, hdr_addr_dw} +
            ((hdr_length == 10'h000) ? DW_PER_4K : {1'b0, hdr_length});
        intx = msg && hdr_msg_code[7:3] == MSG_INTX_TOP;
        c = '0;
        c[C_TAG] = req && !ext_tag_en && hdr_tag[7:5] != 3'h0;
        c[C_CROSS4K] = hdr_type == TYPE_MEM && hdr_fmt[FMT_DATA_BIT] &&
            span > DW_PER_4K;
        c[C_IO] = hdr_type == TYPE_IO && bad;
        c[C_CFG] = cfg && bad;
        c[C_FUNC] = cfg && !func_enabled[hdr_func];
        c[C_INTX_DIR] = intx && !port_downstream;
        c[C_INTX_TC] = intx && tcb;
        c[C_PM_TC] = msg && tcb && hdr_msg_code inside {MSG_PM_NAK,
            MSG_PM_PME, MSG_PME_OFF, MSG_PME_ACK};
        c[C_ERR_TC] = msg && tcb && hdr_msg_code inside {MSG_ERR_COR,
            MSG_ERR_NF, MSG_ERR_FAT};
        c[C_UNLOCK_TC] = msg && tcb && hdr_msg_code == MSG_UNLOCK;
        c[C_SSPL_TC] = msg && tcb && hdr_msg_code == MSG_SSPL;
        return c;
    endfunction

    task automatic check_bit(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %b, seen %b", what, e, g);
        end
    endtask

    task automatic check_cause(input logic [CAUSE_W-1:0] e,
        input logic [CAUSE_W-1:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected chk_cause: expected %h, seen %h", e, g);
        end
    endtask

    // Result of the previous cycle's header is compared, then a new one
    task automatic tick();
        @(negedge core_clk);
        check_bit("chk_valid", pend_v, chk_valid);
        check_bit("chk_malformed", |pend_c, chk_malformed);
        check_cause(pend_c, chk_cause);
        check_bit("report_ur", pend_v && pend_u[1], report_ur);
        check_bit("drop_tlp", pend_v && (|pend_c || |pend_u), drop_tlp);
        pend_v = 1'b0;
        pend_c = '0;
        pend_u = '0;
    endtask

    task automatic clean(input logic [4:0] t);
        tick();
        {hdr_fmt, hdr_tc, hdr_attr, hdr_at, hdr_last_be} = '0;
        {hdr_tag, hdr_addr_dw, hdr_func, hdr_msg_code} = '0;
        hdr_type = t;
        hdr_length = LEN_ONE_DW;
        {ext_tag_en, port_downstream, func_enabled} = {2'b11, 8'hff};
    endtask

    task automatic go();
        hdr_valid = 1'b1;
        pend_v = 1'b1;
        pend_c = exp_cause();
        pend_u = exp_user();
    endtask

    task automatic summarize();
        $display("errors %0d, checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================
    // Tests
    // ==========================================
    initial begin
        repeat (6000) @(posedge core_clk);
        err_count++;
        summarize();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk) arst_n = 1'b1;
        clean(TYPE_IO); hdr_length = 10'h002; go();
        tick();
        hdr_valid = 1'b0;
        // User side corner cases
        clean(TYPE_MEM); hdr_fmt = 3'h4; go();
        clean(TYPE_MEM); hdr_addr_dw = 10'h3ff; hdr_length = 10'h002; go();
        clean(5'h10); hdr_msg_code = 8'h10; hdr_tc = 3'h2; go();
        clean(TYPE_MEM_LK); ext_tag_en = 1'b0; hdr_tag = 8'h80; go();
        clean(5'h06); go();
        clean(5'h10); hdr_msg_code = 8'h7f; go();
        // Each field restriction alone, back to back
        for (int t = 0; t < 3; t++) begin
            for (int i = 0; i < 5; i++) begin
                clean(t == 0 ? TYPE_IO : (t == 1 ? TYPE_CFG0 : TYPE_CFG1));
                case (i)
                    0: hdr_tc = 3'h4;
                    1: hdr_attr = 2'h2;
                    2: hdr_at = 2'h1;
                    3: hdr_length = 10'h000;
                    default: hdr_last_be = 4'h8;
                endcase
                go();
            end
        end
        for (int f = 3; f < 5; f++) begin
            clean(TYPE_CFG0); func_enabled = 8'h0f; hdr_func = 3'(f); go();
        end
        for (int i = 0; i < 5; i++) begin
            clean(TYPE_MEM); hdr_fmt = (i == 4) ? 3'h0 : 3'h2;
            hdr_addr_dw = (i < 2) ? 10'h3ff : 10'(i - 2);
            hdr_length = (i == 1) ? 10'h002 : ((i < 2) ? 10'h001 : 10'h000);
            go();
        end
        for (int i = 0; i < 3; i++) begin
            clean(i == 2 ? 5'h10 : TYPE_MEM_LK); ext_tag_en = 1'b0;
            hdr_tag = (i == 0) ? 8'h1f : 8'h20; go();
        end
        for (int i = 0; i < 24; i++) begin
            clean(5'h10 | 5'(i % 8)); hdr_msg_code = codes[i % 12];
            hdr_tc = (i < 12) ? 3'h1 : 3'h0; port_downstream = i[0];
            go();
        end
        for (int n = 0; n < 2000; n++) begin
            tick();
            r1 = rnd();
            r2 = rnd();
            case (r1[2:0])
                3'h0: hdr_type = TYPE_MEM;
                3'h1: hdr_type = TYPE_MEM_LK;
                3'h2: hdr_type = TYPE_IO;
                3'h3: hdr_type = TYPE_CFG0;
                3'h4: hdr_type = TYPE_CFG1;
                default: hdr_type = {2'b10, r1[5:3]};
            endcase
            hdr_tc = r1[8] ? 3'h0 : r1[11:9];
            hdr_attr = r1[12] ? 2'h0 : r1[14:13];
            hdr_at = r1[15] ? 2'h0 : r1[17:16];
            hdr_length = r1[18] ? 10'h001 : r2[9:0];
            hdr_last_be = r1[19] ? 4'h0 : r2[13:10];
            hdr_msg_code = r1[20] ? codes[r1[24:21] % 12] : r2[21:14];
            {hdr_tag, hdr_addr_dw} = {r2[31:24], r1[31:25], r2[2:0]};
            {hdr_fmt, hdr_func, func_enabled} = {1'b0, r2[23:22], r2[31:21]};
            {ext_tag_en, port_downstream} = r1[7:6];
            if (r2[0] | r2[5])
                go();
            else
                hdr_valid = 1'b0;
        end
        tick();
        hdr_valid = 1'b0;
        tick();
        summarize();
    end
endmodule
